// file: pkg/dal_map.svh
`ifndef DAL_MAP_SVH
`define DAL_MAP_SVH

// ****************************************************************
// Debug space layout of the comparator bank
// ****************************************************************
`define DAL_NUM_BP 4
`define DAL_NUM_WP 2
`define DAL_IDX_W 4
`define DAL_IDX_BP0 4'h0
`define DAL_IDX_WP0 4'h4
`define DAL_IDX_STATUS 4'h8
`define DAL_CMP_EN_BIT 0

// ****************************************************************
// Reset values
// ****************************************************************
`define DAL_CMP_RST 32'h0000_0000

`endif

// file: pkg/dal_pkg.sv
package dal_pkg;

	// Access state of the debug port.
	typedef enum logic [2:0] {
		DAL_LOAD = 3'b000,
		DAL_OPEN = 3'b001,
		DAL_OFF = 3'b010,
		DAL_ERASED = 3'b011,
		DAL_LOCKED = 3'b100
	} dal_state_t;

endpackage : dal_pkg

// file: rtl/dal_cmp.sv
`timescale 1ns/1ps
`default_nettype none
`include "dal_map.svh"

// One match comparator: a stored value and enable against a live value.
module dal_cmp #(
	parameter int W = 32
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Configuration write.
	input wire logic cfg_we,
	input wire logic [W-1:0] cfg_val,
	input wire logic cfg_en,
	// Live value to compare.
	input wire logic obs_valid,
	input wire logic [W-1:0] obs_val,
	// Stored state and match.
	output logic [W-1:0] cur_val,
	output logic cur_en,
	output logic hit
);

	// Stored compare value and enable.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cur_val <= `DAL_CMP_RST;
			cur_en <= 1'b0;
		end else if (cfg_we) begin
			cur_val <= cfg_val;
			cur_en <= cfg_en;
		end
	end

	// Registered match so the halt path has a clean timing start.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hit <= 1'b0;
		end else begin
			hit <= cur_en && obs_valid && (obs_val == cur_val);
		end
	end

endmodule : dal_cmp

`default_nettype wire

// file: rtl/dal_top.sv
// Summary of operation
// - Debug enabled after reset unless storage holds off or secure.
// - Only firmware can disable debug, never link.
// - Re-enable only after erase, unprotect, firmware.
// - Maximum security permanently blocks all interfaces.
// - Debug link reaches all programming and debug.
// - Four address and two data comparators.
`timescale 1ns/1ps
`default_nettype none
`include "dal_map.svh"

module dal_top #(
	parameter int AW = 32,
	parameter int DW = 32
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Stored lock state read from non-volatile storage.
	input wire logic nv_valid,
	input wire logic nv_dbg_off,
	input wire logic nv_secure,
	// Updates written back to non-volatile storage.
	output logic nv_wr_dbg_off,
	output logic nv_wr_dbg_on,
	output logic nv_wr_secure,
	// Firmware controls.
	input wire logic fw_dbg_disable,
	input wire logic fw_dbg_enable,
	input wire logic fw_secure,
	// Flash status.
	input wire logic flash_erased,
	input wire logic flash_unprot,
	// Debug link transactions.
	input wire logic link_req_valid,
	output logic link_req_ready,
	input wire logic link_req_write,
	input wire logic [`DAL_IDX_W-1:0] link_req_idx,
	input wire logic [DW-1:0] link_req_wdata,
	output logic link_rsp_valid,
	output logic link_rsp_err,
	output logic [DW-1:0] link_rsp_rdata,
	// Programming and test requests from the link.
	input wire logic link_prog_start,
	input wire logic link_prog_abort,
	input wire logic link_test_req,
	output logic prog_start,
	output logic prog_abort,
	output logic test_en,
	// Core observation and halt.
	input wire logic cpu_pc_valid,
	input wire logic [AW-1:0] cpu_pc,
	input wire logic cpu_data_valid,
	input wire logic [DW-1:0] cpu_data,
	output logic bp_hit,
	output logic wp_hit,
	// Status.
	output logic dbg_open,
	output logic dev_locked
);

	// ****************************************************************
	// Access state
	// ****************************************************************

	dal_pkg::dal_state_t state_q;
	dal_pkg::dal_state_t state_d;
	logic grant;
	logic erase_ok;

	// Erasing alone is not enough; protection must also be cleared.
	assign erase_ok = flash_erased && flash_unprot;

	// Next state; no link input appears here on purpose.
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			dal_pkg::DAL_LOAD: begin
				if (nv_valid) begin
					if (nv_secure) begin
						state_d = dal_pkg::DAL_LOCKED;
					end else if (nv_dbg_off) begin
						state_d = dal_pkg::DAL_OFF;
					end else begin
						state_d = dal_pkg::DAL_OPEN;
					end
				end
			end
			dal_pkg::DAL_OPEN: begin
				if (fw_secure) begin
					state_d = dal_pkg::DAL_LOCKED;
				end else if (fw_dbg_disable) begin
					state_d = dal_pkg::DAL_OFF;
				end
			end
			dal_pkg::DAL_OFF: begin
				if (fw_secure) begin
					state_d = dal_pkg::DAL_LOCKED;
				end else if (erase_ok) begin
					state_d = dal_pkg::DAL_ERASED;
				end
			end
			dal_pkg::DAL_ERASED: begin
				if (fw_secure) begin
					state_d = dal_pkg::DAL_LOCKED;
				end else if (fw_dbg_enable) begin
					state_d = dal_pkg::DAL_OPEN;
				end
			end
			dal_pkg::DAL_LOCKED: begin
				state_d = dal_pkg::DAL_LOCKED;
			end
			default: begin
				// An illegal code fails safe into the permanent lock.
				state_d = dal_pkg::DAL_LOCKED;
			end
		endcase
	end

	// State register; reset always reloads from storage first.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= dal_pkg::DAL_LOAD;
		end else begin
			state_q <= state_d;
		end
	end

	// Write-back pulses keep storage in step with every transition except the load and OFF to ERASED.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			nv_wr_dbg_off <= 1'b0;
			nv_wr_dbg_on <= 1'b0;
			nv_wr_secure <= 1'b0;
		end else begin
			nv_wr_secure <= (state_q != dal_pkg::DAL_LOCKED)
				&& (state_q != dal_pkg::DAL_LOAD)
				&& (state_d == dal_pkg::DAL_LOCKED);
			nv_wr_dbg_off <= (state_q == dal_pkg::DAL_OPEN)
				&& (state_d == dal_pkg::DAL_OFF);
			nv_wr_dbg_on <= (state_q == dal_pkg::DAL_ERASED)
				&& (state_d == dal_pkg::DAL_OPEN);
		end
	end

	assign grant = (state_q == dal_pkg::DAL_OPEN);
	assign dbg_open = grant;
	assign dev_locked = (state_q == dal_pkg::DAL_LOCKED);

	// ****************************************************************
	// Programming and test gating
	// ****************************************************************

	// Registered gates; when blocked, start and abort have no effect.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prog_start <= 1'b0;
			prog_abort <= 1'b0;
			test_en <= 1'b0;
		end else begin
			prog_start <= grant && link_prog_start;
			prog_abort <= grant && link_prog_abort;
			test_en <= grant && link_test_req;
		end
	end

	// ****************************************************************
	// Comparator bank
	// ****************************************************************

	logic take;
	logic [`DAL_NUM_BP-1:0] bp_hits;
	logic [`DAL_NUM_WP-1:0] wp_hits;
	logic [`DAL_NUM_BP-1:0] bp_en;
	logic [`DAL_NUM_WP-1:0] wp_en;
	logic [AW-1:0] bp_val [`DAL_NUM_BP];
	logic [DW-1:0] wp_val [`DAL_NUM_WP];

	// Nothing is taken while the stored state is still loading.
	assign link_req_ready = (state_q != dal_pkg::DAL_LOAD);
	assign take = link_req_valid && link_req_ready;

	genvar gi;
	generate
		for (gi = 0; gi < `DAL_NUM_BP; gi++) begin : g_bp
			dal_cmp #(.W(AW)) u_bp (
				.clk(clk),
				.rst_n(rst_n),
				.cfg_we(take && grant && link_req_write
					&& (link_req_idx == `DAL_IDX_BP0
					+ `DAL_IDX_W'(gi))),
				.cfg_val(AW'(link_req_wdata)),
				.cfg_en(link_req_wdata[`DAL_CMP_EN_BIT]),
				.obs_valid(cpu_pc_valid && grant),
				.obs_val(cpu_pc),
				.cur_val(bp_val[gi]),
				.cur_en(bp_en[gi]),
				.hit(bp_hits[gi])
			);
		end
		for (gi = 0; gi < `DAL_NUM_WP; gi++) begin : g_wp
			dal_cmp #(.W(DW)) u_wp (
				.clk(clk),
				.rst_n(rst_n),
				.cfg_we(take && grant && link_req_write
					&& (link_req_idx == `DAL_IDX_WP0
					+ `DAL_IDX_W'(gi))),
				.cfg_val(link_req_wdata),
				.cfg_en(link_req_wdata[`DAL_CMP_EN_BIT]),
				.obs_valid(cpu_data_valid && grant),
				.obs_val(cpu_data),
				.cur_val(wp_val[gi]),
				.cur_en(wp_en[gi]),
				.hit(wp_hits[gi])
			);
		end
	endgenerate

	// Bit 0 of a value doubles as the enable, a trade for fewer ports.
	assign bp_hit = |bp_hits;
	assign wp_hit = |wp_hits;

	// ****************************************************************
	// Link response
	// ****************************************************************

	logic [DW-1:0] rd_d;
	logic hit_idx;

	// Read mux over the comparator bank and a status word.
	always_comb begin
		rd_d = '0;
		hit_idx = 1'b1;
		if (link_req_idx < `DAL_IDX_WP0) begin
			rd_d = DW'(bp_val[link_req_idx[1:0]]);
		end else if (link_req_idx
			< `DAL_IDX_WP0 + `DAL_IDX_W'(`DAL_NUM_WP)) begin
			rd_d = wp_val[link_req_idx[0]];
		end else if (link_req_idx == `DAL_IDX_STATUS) begin
			rd_d = DW'({wp_en, bp_en});
		end else begin
			hit_idx = 1'b0;
		end
	end

	// One answer per taken request, one cycle later; blocked gives error.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			link_rsp_valid <= 1'b0;
			link_rsp_err <= 1'b0;
			link_rsp_rdata <= '0;
		end else begin
			link_rsp_valid <= take;
			link_rsp_err <= take && !(grant && hit_idx);
			link_rsp_rdata <= (take && grant && !link_req_write)
				? rd_d : '0;
		end
	end

endmodule : dal_top

`default_nettype wire

// file: verification/dal_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ***
// Lock checks
// ***
module dal_chk (
	// Watched top ports.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic nv_valid,
	input wire logic nv_dbg_off,
	input wire logic nv_secure,
	input wire logic fw_dbg_disable,
	input wire logic fw_dbg_enable,
	input wire logic fw_secure,
	input wire logic link_req_valid,
	input wire logic link_req_ready,
	input wire logic link_rsp_valid,
	input wire logic link_rsp_err,
	input wire logic prog_start,
	input wire logic prog_abort,
	input wire logic test_en,
	input wire logic bp_hit,
	input wire logic dbg_open,
	input wire logic dev_locked
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_load_open: assert property (
		nv_valid && !nv_dbg_off && !nv_secure && !link_req_ready
		|=> dbg_open) else $error("not open after load");
	a_load_silent: assert property (
		!link_req_ready |=> !link_rsp_valid) else $error("answer in load");
	a_rsp_next: assert property (
		link_req_valid && link_req_ready |=> link_rsp_valid)
		else $error("no answer");
	a_closed_err: assert property (
		link_req_valid && link_req_ready && !dbg_open |=> link_rsp_err)
		else $error("closed access not refused");
	a_fw_off: assert property (
		dbg_open && fw_dbg_disable && !fw_secure |=> !dbg_open)
		else $error("disable ignored");
	a_reopen_fw: assert property (
		$rose(dbg_open) && $past(link_req_ready) |-> $past(fw_dbg_enable))
		else $error("reopened without firmware");
	a_lock_keep: assert property (
		dev_locked |=> dev_locked) else $error("lock lost");
	a_lock_block: assert property (
		dev_locked ##1 dev_locked |-> !(prog_start || prog_abort || test_en))
		else $error("locked port active");
	// Main scenarios seen.
	c_hit: cover property (bp_hit);
	c_err: cover property (link_rsp_err);
	c_lock: cover property (dev_locked);
endmodule : dal_chk
bind dal_top dal_chk dal_chk_inst (.*);
`default_nettype wire

// file: verification/dal_probe.sv
`timescale 1ns/1ps
`default_nettype none
// ***
// Probe model
// ***
module dal_probe (
	// Request handshake.
	input wire logic clk,
	input wire logic link_req_ready,
	output logic link_req_valid,
	output logic link_req_write,
	output logic [3:0] link_req_idx,
	output logic [31:0] link_req_wdata
);
	// Idle lines start low.
	initial begin
		{link_req_valid, link_req_write} = '0;
		{link_req_idx, link_req_wdata} = '0;
	end
	// A random gap first, so answers are met both at once and late.
	// Released lines show the inverse, so no stale copy can pass.
	task automatic xfer(input logic w, input logic [3:0] i,
		input logic [31:0] d);
		repeat ($urandom % 3) @(posedge clk);
		@(posedge clk);
		{link_req_valid, link_req_write} <= {1'b1, w};
		{link_req_idx, link_req_wdata} <= {i, d};
		do @(posedge clk); while (link_req_ready !== 1'b1);
		{link_req_valid, link_req_write} <= {1'b0, ~w};
		{link_req_idx, link_req_wdata} <= ~{i, d};
	endtask : xfer
endmodule : dal_probe
`default_nettype wire

// file: verification/dal_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ***
// Bench
// ***
module dal_top_bench;
	logic clk = 0, rst_n = 0, nv_valid = 0, nv_dbg_off = 0, nv_secure = 0;
	logic fw_dbg_disable = 0, fw_dbg_enable = 0, fw_secure = 0;
	logic flash_erased = 0, flash_unprot = 0, cpu_pc_valid = 0;
	logic link_prog_start = 0, link_prog_abort = 0, link_test_req = 0;
	logic link_req_valid, link_req_ready, link_req_write, link_rsp_valid;
	logic link_rsp_err, prog_start, prog_abort, test_en, cpu_data_valid = 0;
	logic bp_hit, wp_hit, dbg_open, dev_locked;
	logic nv_wr_dbg_off, nv_wr_dbg_on, nv_wr_secure;
	logic [3:0] link_req_idx;
	logic [31:0] link_req_wdata, link_rsp_rdata, cpu_pc = 0, cpu_data = 0;
	logic [31:0] val [6];
	logic [32:0] e;
	logic [32:0] rq [$];
	int n_errors = 0, cmp_count = 0;

	// Clock, design and probe.
	always #2.5 clk = ~clk;
	dal_top dal_top_inst (.*);
	dal_probe dal_probe_inst (.*);

	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	// Note the answer first, so the monitor always finds it queued.
	task automatic lx(input logic w, input logic [3:0] i,
		input logic [31:0] d, input logic [32:0] x);
		rq.push_back(x);
		dal_probe_inst.xfer(w, i, d);
	endtask : lx

	// Each answer retires the oldest note; mid-cycle, so it has settled.
	always @(negedge clk) begin
		if (link_rsp_valid === 1'b1) begin
			if (rq.size() == 0) chk(1, 0);
			else
				chk({link_rsp_err, link_rsp_rdata}, rq.pop_front());
		end
	end

	task automatic rst(input logic off, input logic sec);
		@(posedge clk);
		{rst_n, nv_valid, nv_dbg_off, nv_secure} <= {2'b00, off, sec};
		repeat (8) @(posedge clk);
		{rst_n, nv_valid} <= 2'b11;
		repeat (3) @(posedge clk);
		#1;
	endtask : rst

	// Pulses land one cycle on; three cycles of samples are gathered.
	task automatic fw(input logic [2:0] f, input logic [2:0] x);
		logic [2:0] seen;
		seen = 0;
		@(posedge clk);
		{fw_dbg_disable, fw_dbg_enable, fw_secure} <= f;
		repeat (3) begin
			@(posedge clk);
			{fw_dbg_disable, fw_dbg_enable, fw_secure} <= 0;
			#1 seen |= {nv_wr_dbg_off, nv_wr_dbg_on, nv_wr_secure};
		end
		chk(seen, x);
	endtask : fw

	task automatic pg(input logic g);
		for (int j = 0; j < 3; j++) begin
			@(posedge clk);
			{link_prog_start, link_prog_abort, link_test_req} <= 3'b1 << j;
			@(posedge clk);
			{link_prog_start, link_prog_abort, link_test_req} <= 0;
			#1 chk({prog_start, prog_abort, test_en}, g << j);
		end
	endtask : pg

	task automatic hit(input logic d, input logic [31:0] v, input logic x);
		@(posedge clk);
		if (d) {cpu_data_valid, cpu_data} <= {1'b1, v};
		else {cpu_pc_valid, cpu_pc} <= {1'b1, v};
		@(posedge clk);
		{cpu_pc_valid, cpu_data_valid} <= 0;
		#1 chk({bp_hit, wp_hit}, {!d & x, d & x});
	endtask : hit

	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done

	// Main sequence.
	initial begin
		void'($urandom(31));
		rst(0, 0);
		chk({dbg_open, link_req_ready}, 2'b11);
		for (int i = 0; i < 6; i++) begin
			val[i] = $urandom | 32'h1;
			lx(1, i, val[i], 0);
		end
		for (int i = 0; i < 16; i++) begin
			e = i < 6 ? {1'b0, val[i]} : 33'h1_0000_0000;
			lx(0, i, 0, i == 8 ? 33'h3f : e);
		end
		for (int i = 0; i < 6; i++) begin
			hit(i > 3, val[i], 1);
			hit(i > 3, val[i] ^ 32'h2, 0);
		end
		pg(1);
		$display("test open done");
		fw(3'b100, 3'b100);
		lx(0, 0, 0, 33'h1_0000_0000);
		pg(0);
		hit(0, val[0], 0);
		fw(3'b010, 0);
		chk(dbg_open, 0);
		// An erase that leaves protection set must not allow reopening.
		@(posedge clk);
		flash_erased <= 1'b1;
		@(posedge clk);
		flash_erased <= 1'b0;
		fw(3'b010, 0);
		chk(dbg_open, 0);
		@(posedge clk);
		{flash_erased, flash_unprot} <= 2'b11;
		@(posedge clk);
		{flash_erased, flash_unprot} <= 0;
		fw(3'b010, 3'b010);
		chk(dbg_open, 1);
		$display("test reopen done");
		fw(3'b001, 3'b001);
		chk(dev_locked, 1);
		fw(3'b010, 0);
		pg(0);
		lx(1, 0, 32'h1, 33'h1_0000_0000);
		$display("test lock done");
		rst(0, 1);
		chk({dev_locked, dbg_open}, 2'b10);
		lx(0, 8, 0, 33'h1_0000_0000);
		rst(1, 0);
		chk({dev_locked, dbg_open}, 2'b00);
		pg(0);
		repeat (4) @(posedge clk);
		chk(rq.size(), 0);
		$display("test reload done");
		test_done();
	end

	// The run needs about 200 cycles; this cuts a hang short.
	initial begin
		#20000;
		n_errors++;
		test_done();
	end
endmodule : dal_top_bench
`default_nettype wire
